//--- dssw_status_word.sv
`default_nettype none
// Summary of operation
// - Not ready: bits 6,3,2,1,0 low
// - Switch-on disabled: bit 6 only
// - Ready, switched on, enabled codes
// - Quick stop, fault reaction, fault codes
// - Bit 4 only while bus voltage good
// - Block 3-to-4 while voltage low
// - Bit 7 for class 0 warning
// - Bit 7 held at least 100 ms
// - Fault reset clears bit 7 at once
// - Bit 8 while halt active
// - Bit 9 when fieldbus has control
// - Parameters stay accessible without control
// - Bit 11 meaning set by selector
// - Bits 10, 12 mode-dependent flags
// - Bit 13 for must-correct errors
// - Bit 14 clears on mode start
// - Bit 14 sets after standstill
// - No bit 14 between chained modes
// - Bit 15 once zero point valid
// - Zero point kept with power off
module dssw_status_word
  import dssw_pkg::*;
#(
  parameter int WARN_HOLD = dssw_pkg::WARN_HOLD_CYC // Shortenable hold
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  drive_state,            // Current state code
  input  wire logic        dc_bus_ok,              // Voltage judgement
  input  wire logic        active_warning_list,    // Class 0 entry present
  input  wire logic [15:0] drive_control_word,     // From fieldbus master
  input  wire logic        fieldbus_has_control,   // Access channel owner
  input  wire logic        internal_limit_meaning_select, // Bit 11 mode
  input  wire logic        limit_active,           // Current/torque limit
  input  wire logic        sw_limit_active,        // Alternate limit source
  input  wire logic        mode_flag_a,            // Mode flag to bit 10
  input  wire logic        mode_flag_b,            // Mode flag to bit 12
  input  wire logic        blocking_error,         // Must-correct error
  input  wire logic        mode_start,             // Mode begins, pulse
  input  wire logic        mode_stop,              // Mode ends/interrupted
  input  wire logic        motor_standstill,       // Motor at rest
  input  wire logic        zero_point_set,         // Referencing done
  input  wire logic        zero_point_lost,        // Position lost
  input  wire logic        status_write,           // Write attempt strobe
  output logic             allow_ready_transition, // 3-to-4 permit
  output logic [15:0]      drive_status_word       // Read-only status
);
  import dssw_pkg::*;

  // =============================================================
  // Input synchronisers (pins from other domains)
  logic [1:0]  bus_ok_s_r;      // Voltage sync stages
  logic [1:0]  warn_s_r;        // Warning sync stages
  logic [1:0]  still_s_r;       // Standstill sync stages
  logic [15:0] ctl_r;           // Previous control word
  logic        fr_edge;         // Fault reset edge

  // Two flops each; logic reads only the second stage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bus_ok_s_r <= 2'h0;
      warn_s_r   <= 2'h0;
      still_s_r  <= 2'h0;
      ctl_r      <= 16'h0000;
    end
    else
    begin
      bus_ok_s_r <= {bus_ok_s_r[0], dc_bus_ok};
      warn_s_r   <= {warn_s_r[0], active_warning_list};
      still_s_r  <= {still_s_r[0], motor_standstill};
      ctl_r      <= drive_control_word;
    end
  end

  // Rising control bit 7 is the fault reset
  assign fr_edge = drive_control_word[CW_FAULT_RST] & ~ctl_r[CW_FAULT_RST];

  // =============================================================
  // Warning bit with minimum hold
  logic                  warn_r, warn_nxt;
  logic [WARN_CNT_W-1:0] hold_r, hold_nxt;   // Remaining hold cycles

  // Set wins over hold expiry; fault reset beats the hold
  always_comb
  begin
    warn_nxt = warn_r;
    hold_nxt = hold_r;
    if (hold_r != '0)
      hold_nxt = hold_r - 1'b1;
    if (fr_edge)
    begin
      warn_nxt = 1'b0;
      hold_nxt = '0;
    end
    else if (warn_s_r[1])
    begin
      if (!warn_r)
        hold_nxt = WARN_CNT_W'(WARN_HOLD - 1);
      warn_nxt = 1'b1;
    end
    else if (hold_r == '0)
      warn_nxt = 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      warn_r <= 1'b0;
      hold_r <= '0;
    end
    else
    begin
      warn_r <= warn_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Cycles bit 7 has stood since its rise; feeds the hold check only
  logic [WARN_CNT_W-1:0] warn_age_r, warn_age_nxt;

  // Saturates so a long warning cannot wrap back to a short age
  always_comb
  begin
    warn_age_nxt = warn_age_r;
    if (!warn_r)
      warn_age_nxt = '0;
    else if (warn_age_r != '1)
      warn_age_nxt = warn_age_r + 1'b1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      warn_age_r <= '0;
    else
      warn_age_r <= warn_age_nxt;
  end

  // =============================================================
  // Processing done and zero point tracking
  logic end_r, end_nxt;        // Bit 14 state
  logic run_r, run_nxt;        // A mode is processing
  logic wait_r, wait_nxt;      // Ended, awaiting standstill
  logic ref_r, ref_nxt;        // Zero point valid

  // A new start while waiting cancels the pending rise
  always_comb
  begin
    end_nxt  = end_r;
    run_nxt  = run_r;
    wait_nxt = wait_r;
    ref_nxt  = ref_r;
    if (mode_start)
    begin
      end_nxt  = 1'b0;
      run_nxt  = 1'b1;
      wait_nxt = 1'b0;
    end
    else if (mode_stop && run_r)
    begin
      run_nxt  = 1'b0;
      wait_nxt = 1'b1;
    end
    else if (wait_r && still_s_r[1])
    begin
      wait_nxt = 1'b0;
      end_nxt  = 1'b1;
    end
    // Set wins over loss; power stage state is not consulted
    if (zero_point_set)
      ref_nxt = 1'b1;
    else if (zero_point_lost)
      ref_nxt = 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      end_r  <= 1'b1;
      run_r  <= 1'b0;
      wait_r <= 1'b0;
      ref_r  <= 1'b0;
    end
    else
    begin
      end_r  <= end_nxt;
      run_r  <= run_nxt;
      wait_r <= wait_nxt;
      ref_r  <= ref_nxt;
    end
  end

  // =============================================================
  // Status word assembly
  logic [15:0] sw_nxt;
  logic        allow_nxt;

  // Whole word rebuilt each cycle; writes have no path in
  always_comb
  begin
    sw_nxt = 16'h0000;
    case (drive_state)
      DSSW_ST_NOT_READY:   sw_nxt[6:0] = 7'h00;
      DSSW_ST_SW_ON_DIS:   sw_nxt[6:0] = 7'h40;
      DSSW_ST_READY:       sw_nxt[6:0] = 7'h21;
      DSSW_ST_SWITCHED_ON: sw_nxt[6:0] = 7'h23;
      DSSW_ST_OP_ENABLED:  sw_nxt[6:0] = 7'h27;
      DSSW_ST_QSTOP:       sw_nxt[6:0] = 7'h07;
      DSSW_ST_FAULT_REACT: sw_nxt[6:0] = 7'h0f;
      DSSW_ST_FAULT:       sw_nxt[6:0] = 7'h08;
      default:             sw_nxt[6:0] = 7'h00;
    endcase
    sw_nxt[BIT_VOLT]   = bus_ok_s_r[1];
    sw_nxt[BIT_WARN]   = warn_r;
    sw_nxt[BIT_HALT]   = drive_control_word[CW_HALT];
    sw_nxt[BIT_REMOTE] = fieldbus_has_control;
    sw_nxt[BIT_TARGET] = mode_flag_a;
    sw_nxt[BIT_LIMIT]  = internal_limit_meaning_select ?
                         sw_limit_active : limit_active;
    sw_nxt[BIT_MODE]   = mode_flag_b;
    sw_nxt[BIT_ERR]    = blocking_error;
    sw_nxt[BIT_END]    = end_r;
    sw_nxt[BIT_REF_OK] = ref_r;
    // Permit only from switch-on disabled with good voltage
    allow_nxt = (drive_state == DSSW_ST_SW_ON_DIS) && bus_ok_s_r[1];
  end

  // Status_write is accepted and dropped; reading never depends
  // on who controls the drive
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      drive_status_word      <= STATUS_RESET;
      allow_ready_transition <= 1'b0;
    end
    else
    begin
      drive_status_word      <= sw_nxt;
      allow_ready_transition <= allow_nxt;
    end
  end

  // =============================================================
  // Checks
  chk_not_ready_code: assert property (@(posedge clk) disable iff (reset)
    drive_state == DSSW_ST_NOT_READY |=> (drive_status_word[6:0] & 7'h4f) == 7'h00)
    else $error("not ready code wrong");
  chk_sw_dis_code: assert property (@(posedge clk) disable iff (reset)
    drive_state == DSSW_ST_SW_ON_DIS |=> (drive_status_word[6:0] & 7'h4f) == 7'h40)
    else $error("switch on disabled code wrong");
  chk_op_en_code: assert property (@(posedge clk) disable iff (reset)
    drive_state == DSSW_ST_OP_ENABLED |=> (drive_status_word[6:0] & 7'h6f) == 7'h27)
    else $error("operation enabled code wrong");
  chk_fault_code: assert property (@(posedge clk) disable iff (reset)
    drive_state == DSSW_ST_FAULT |=> (drive_status_word[6:0] & 7'h4f) == 7'h08)
    else $error("fault code wrong");
  chk_volt_bit: assert property (@(posedge clk) disable iff (reset)
    drive_status_word[BIT_VOLT] |-> $past(dc_bus_ok, 3))
    else $error("voltage bit without good bus");
  chk_ready_gate: assert property (@(posedge clk) disable iff (reset)
    allow_ready_transition |-> $past(drive_state) == DSSW_ST_SW_ON_DIS)
    else $error("transition permit in wrong state");
  chk_warn_clear: assert property (@(posedge clk) disable iff (reset)
    fr_edge |=> !warn_r)
    else $error("fault reset left warning set");
  chk_warn_hold: assert property (@(posedge clk) disable iff (reset)
    $rose(warn_r) && !fr_edge |-> warn_r [*2])
    else $error("warning dropped before hold");
  chk_halt_bit: assert property (@(posedge clk) disable iff (reset)
    drive_control_word[CW_HALT] |=> drive_status_word[BIT_HALT])
    else $error("halt bit missing");
  chk_end_clear: assert property (@(posedge clk) disable iff (reset)
    mode_start |=> !end_r ##1 !drive_status_word[BIT_END])
    else $error("done bit not cleared on start");
  chk_warn_set: assert property (@(posedge clk) disable iff (reset)
    warn_s_r[1] && !fr_edge |=> warn_r)
    else $error("warning present but bit 7 low");
  chk_warn_min: assert property (@(posedge clk) disable iff (reset)
    $fell(warn_r) && !$past(fr_edge) |-> $past(warn_age_r) >= WARN_HOLD - 1)
    else $error("warning bit dropped before minimum hold");
  chk_remote_bit: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> drive_status_word[BIT_REMOTE] == $past(fieldbus_has_control))
    else $error("remote bit does not follow control owner");
  chk_limit_mux: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> drive_status_word[BIT_LIMIT] ==
      $past(internal_limit_meaning_select ? sw_limit_active : limit_active))
    else $error("limit bit wrong for selected meaning");
  chk_mode_flags: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> drive_status_word[BIT_TARGET] == $past(mode_flag_a) &&
      drive_status_word[BIT_MODE] == $past(mode_flag_b))
    else $error("mode flags not passed through");
  chk_err_bit: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> drive_status_word[BIT_ERR] == $past(blocking_error))
    else $error("error bit does not follow blocking error");
  chk_end_wait: assert property (@(posedge clk) disable iff (reset)
    $rose(end_r) |-> $past(still_s_r[1]))
    else $error("done bit rose before standstill");
  chk_chain_low: assert property (@(posedge clk) disable iff (reset)
    mode_start |=> !wait_r)
    else $error("pending done rise survived a new start");
  chk_zero_set: assert property (@(posedge clk) disable iff (reset)
    zero_point_set |=> ##1 drive_status_word[BIT_REF_OK])
    else $error("zero point bit not set");
  chk_zero_keep: assert property (@(posedge clk) disable iff (reset)
    ref_r && !zero_point_lost |=> ref_r)
    else $error("zero point lost without cause");
endmodule : dssw_status_word
`default_nettype wire

//--- dssw_pkg.sv
`default_nettype none
// =============================================================
// Status word package
package dssw_pkg;
  // Drive operating states, numbered as the drive reports them
  typedef enum logic [3:0]
  {
    DSSW_ST_NOT_READY   = 4'h2,
    DSSW_ST_SW_ON_DIS   = 4'h3,
    DSSW_ST_READY       = 4'h4,
    DSSW_ST_SWITCHED_ON = 4'h5,
    DSSW_ST_OP_ENABLED  = 4'h6,
    DSSW_ST_QSTOP       = 4'h7,
    DSSW_ST_FAULT_REACT = 4'h8,
    DSSW_ST_FAULT       = 4'h9
  } dssw_state_t;

  // Status word bit positions
  localparam int BIT_RDY      = 0;
  localparam int BIT_SWON     = 1;
  localparam int BIT_OPEN     = 2;
  localparam int BIT_FAULT    = 3;
  localparam int BIT_VOLT     = 4;
  localparam int BIT_QSTOP    = 5;
  localparam int BIT_SWDIS    = 6;
  localparam int BIT_WARN     = 7;
  localparam int BIT_HALT     = 8;
  localparam int BIT_REMOTE   = 9;
  localparam int BIT_TARGET   = 10;
  localparam int BIT_LIMIT    = 11;
  localparam int BIT_MODE     = 12;
  localparam int BIT_ERR      = 13;
  localparam int BIT_END      = 14;
  localparam int BIT_REF_OK   = 15;
  // Control word bits the block watches
  localparam int CW_FAULT_RST = 7;
  localparam int CW_HALT      = 8;

  // Reset value of the status word and the state
  localparam logic [15:0] STATUS_RESET = 16'h4000;
  localparam logic [3:0]  STATE_RESET  = 4'h2;

  // Warning minimum hold: 100 ms at 40 MHz
  localparam int CLK_HZ        = 40000000;
  localparam int WARN_HOLD_MS  = 100;
  localparam int WARN_HOLD_CYC = (CLK_HZ / 1000) * WARN_HOLD_MS;
  localparam int WARN_CNT_W    = 22;
endpackage : dssw_pkg
`default_nettype wire

//--- dssw_master_model.sv
`default_nettype none
// =====
// Fieldbus master stand-in
module dssw_master_model
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        fault_req,         // Bench asks for fault reset
  input  wire logic        halt_req,          // Bench asks for halt
  output logic      [15:0] drive_control_word // Word sent to the drive
);
  timeunit 1ns;
  timeprecision 1ps;
  // Reserved bits never touched, so they stay low from reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      drive_control_word <= 16'h0000;
    else
    begin
      // One-cycle request gives a clean low-to-high step
      drive_control_word[7] <= fault_req;
      drive_control_word[8] <= halt_req;
    end
  end
endmodule : dssw_master_model
`default_nettype wire

//--- test_dssw_status_word.sv
`default_nettype none
// =====
// Status word bench
module test_dssw_status_word;
  timeunit 1ns;
  timeprecision 1ps;
  import dssw_pkg::*;
  localparam int HOLD = 20; // Short warning hold
  logic clk, reset, vok, awl, fbc, sel, lim, swl, fa, fb, berr, still, halt, allow;
  logic [3:0]  st;  // Drive state code
  logic [5:0]  pv;  // Pulses: start, stop, zset, zlost, fault, write
  logic [15:0] cw, sw, w;
  int mismatches, num_checks;
  dssw_master_model host (.clk(clk), .reset(reset), .fault_req(pv[4]),
    .halt_req(halt), .drive_control_word(cw));
  dssw_status_word #(.WARN_HOLD(HOLD)) dut (.clk(clk), .reset(reset),
    .drive_state(st), .dc_bus_ok(vok), .active_warning_list(awl),
    .drive_control_word(cw), .fieldbus_has_control(fbc),
    .internal_limit_meaning_select(sel), .limit_active(lim),
    .sw_limit_active(swl), .mode_flag_a(fa), .mode_flag_b(fb),
    .blocking_error(berr), .mode_start(pv[0]), .mode_stop(pv[1]),
    .motor_standstill(still), .zero_point_set(pv[2]),
    .zero_point_lost(pv[3]), .status_write(pv[5]),
    .allow_ready_transition(allow), .drive_status_word(sw));
  // =====
  // Expectations
  function automatic logic [15:0] exp_lo(input int s);
    // State bits 6,5,3,2,1,0 with bit 4 set
    logic [6:0] t [2:9] = '{7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h0f, 7'h08};
    return {9'h000, t[s] | 7'h10};
  endfunction : exp_lo
  function automatic logic [5:0] exp_hi(input logic [7:0] r);
    // Bits 13..8 from error, flags, limit mux, remote, halt
    return {r[1], r[2], r[6] ? r[4] : r[5], r[3], r[7], r[0]};
  endfunction : exp_hi
  // =====
  // Compare and control tasks
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask : chk16
  task chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : chk1
  // Wait, then let the edge's updates land
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task pulse(input int i);
    @(posedge clk) pv[i] <= 1'b1;
    @(posedge clk) pv[i] <= 1'b0;
  endtask : pulse
  task give_verdict();
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  // =====
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  // =====
  // Main sequence
  initial
  begin
    {awl, fbc, sel, lim, swl, fa, fb, berr, halt, pv} = '0;
    {reset, vok, still, st} = {3'b111, 4'h2};
    void'($urandom(32'hcd63a64e));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    cyc(1);
    chk16(sw, STATUS_RESET);
    chk1(allow, 1'b0);
    // Every state code with good voltage
    for (int s = 2; s <= 9; s++)
    begin
      @(posedge clk) st <= 4'(s);
      cyc(5);
      chk16(sw & 16'h007f, exp_lo(s));
    end
    // Low voltage blocks the ready step
    @(posedge clk) {st, vok} <= {4'h3, 1'b0};
    cyc(5);
    chk1(sw[4], 1'b0);
    chk1(allow, 1'b0);
    @(posedge clk) vok <= 1'b1;
    cyc(5);
    chk1(allow, 1'b1);
    // Random flag mixes; all ones and all zeros forced first
    for (int i = 0; i < 30; i++)
    begin
      w[7:0] = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      @(posedge clk) {fbc, sel, lim, swl, fa, fb, berr, halt} <= w[7:0];
      cyc(4);
      chk16({10'h000, sw[13:8]}, {10'h000, exp_hi(w[7:0])});
    end
    // Short warning while moving: held, then released
    @(posedge clk) {st, halt, awl} <= {4'h6, 2'b01};
    cyc(2);
    @(posedge clk) awl <= 1'b0;
    cyc(3);
    chk16(sw & 16'h00af, 16'h00a7);
    cyc(HOLD - 3);
    chk1(sw[7], 1'b1);
    cyc(1);
    chk1(sw[7], 1'b0);
    // Fault reset cuts the hold short
    @(posedge clk) awl <= 1'b1;
    cyc(5);
    @(posedge clk) awl <= 1'b0;
    pulse(4);
    cyc(3);
    chk1(sw[7], 1'b0);
    // Processing end waits for standstill
    pulse(0);
    cyc(2);
    chk1(sw[14], 1'b0);
    @(posedge clk) still <= 1'b0;
    pulse(1);
    cyc(5);
    chk1(sw[14], 1'b0);
    @(posedge clk) still <= 1'b1;
    cyc(5);
    chk1(sw[14], 1'b1);
    // Chained modes keep the flag low
    pulse(0);
    @(posedge clk) still <= 1'b0;
    pulse(1);
    pulse(0);
    @(posedge clk) still <= 1'b1;
    cyc(6);
    chk1(sw[14], 1'b0);
    pulse(1);
    cyc(6);
    chk1(sw[14], 1'b1);
    // Zero point survives power stage off
    pulse(2);
    cyc(3);
    chk1(sw[15], 1'b1);
    @(posedge clk) st <= 4'h3;
    cyc(4);
    chk1(sw[15], 1'b1);
    pulse(3);
    cyc(3);
    chk1(sw[15], 1'b0);
    // Write attempts leave the word alone
    w = sw;
    repeat (3) pulse(5);
    cyc(3);
    chk16(sw, w);
    give_verdict();
  end
endmodule : test_dssw_status_word
`default_nettype wire
